// [logic/tlp_pkg.sv]
`default_nettype none
package tlp_pkg;
    localparam int INSTR_W = 10;
    localparam int PAGE_W = 7;
    localparam int LOW_W = 7;
    localparam int PC_W = PAGE_W + LOW_W;
    localparam int PRESC_W = 8;
    // table lookup: 0010 followed by a six-bit page field
    localparam logic [3:0] TAB_OP_HI = 4'h2;
    localparam int TAB_OP_LSB = 6;
    // prescaler read: 1001110101
    localparam logic [INSTR_W-1:0] PRESC_OP = 10'h275;
    localparam int TAB_CYCLES = 3;
    localparam int PRESC_CYCLES = 1;
    // bank after reset and wake-up selects pages 0 to 63
    localparam logic BANK_RST = 1'b0;
    localparam logic [PAGE_W-1:0] PAGE_RST = 7'h00;
    localparam logic [LOW_W-1:0] LOW_RST = 7'h00;
    localparam logic [PC_W-1:0] PC_RST = 14'h0000;
    localparam logic [3:0] NIB_RST = 4'h0;
    localparam logic [1:0] DP_RST = 2'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FETCH = 3'b010,
        ST_LOAD = 3'b100
    } tab_state_t;

    function automatic logic is_table_op(input logic [INSTR_W-1:0] code);
        is_table_op = (code[INSTR_W-1:TAB_OP_LSB] == TAB_OP_HI);
    endfunction : is_table_op

    function automatic logic is_presc_op(input logic [INSTR_W-1:0] code);
        is_presc_op = (code == PRESC_OP);
    endfunction : is_presc_op
endpackage : tlp_pkg
`default_nettype wire

// [logic/table_lookup_prescaler_read.sv]
// Behaviour
// - table lookup opcode 0010pppppp, three cycles
// - stack pointer increments first; page spans 0-127
// - push pc; jump to page, pointer and accumulator
// - rom word splits into pointer, b, accumulator
// - restore pc from stack, then pop pointer
// - one free stack level needed beforehand
// - bank state picks upper or lower 64 pages
// - prescaler read opcode 1001110101, one cycle
// - prescaler high to b, low to accumulator
`timescale 1ns/1ns
`default_nettype none
module table_lookup_prescaler_read
    import tlp_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // instruction cycle
    input wire logic cycle_en,
    input wire logic instr_valid,
    input wire logic [INSTR_W-1:0] instr_code,
    // core state
    input wire logic [PC_W-1:0] pc_in,
    input wire logic [2:0] data_pointer_high,
    input wire logic [3:0] acc_in,
    input wire logic [PRESC_W-1:0] timer_prescaler_value,
    // bank control
    input wire logic set_bank_op,
    input wire logic reset_bank_op,
    input wire logic wakeup,
    // rom port
    input wire logic [INSTR_W-1:0] rom_data,
    output logic rom_rd,
    output logic [PC_W-1:0] rom_addr,
    // return stack port
    input wire logic [PC_W-1:0] stack_rdata,
    output logic stack_push,
    output logic [PC_W-1:0] stack_wdata,
    output logic stack_pop,
    // register writes
    output logic pc_we,
    output logic [PC_W-1:0] pc_wdata,
    output logic b_we,
    output logic [3:0] b_wdata,
    output logic a_we,
    output logic [3:0] a_wdata,
    output logic dp_we,
    output logic [1:0] dp_wdata,
    // status
    output logic busy,
    output logic bank_upper
);
    tab_state_t state_q, state_d;
    logic bank_q, bank_d;
    logic [PAGE_W-1:0] page_q, page_d;
    logic [LOW_W-1:0] low_q, low_d;
    logic rom_rd_q, rom_rd_d;
    logic [PC_W-1:0] rom_addr_q, rom_addr_d;
    logic push_q, push_d;
    logic [PC_W-1:0] swdata_q, swdata_d;
    logic pop_q, pop_d;
    logic pc_we_q, pc_we_d;
    logic [PC_W-1:0] pc_wdata_q, pc_wdata_d;
    logic b_we_q, b_we_d;
    logic [3:0] b_wdata_q, b_wdata_d;
    logic a_we_q, a_we_d;
    logic [3:0] a_wdata_q, a_wdata_d;
    logic dp_we_q, dp_we_d;
    logic [1:0] dp_wdata_q, dp_wdata_d;
    logic start_tab, start_presc;
    logic busy_q, busy_d;

    assign start_tab = cycle_en && instr_valid && (state_q == ST_IDLE)
        && is_table_op(instr_code);
    assign start_presc = cycle_en && instr_valid && (state_q == ST_IDLE)
        && is_presc_op(instr_code);

    // reset-bank wins over a simultaneous set-bank, so that wake-up is safe
    always_comb
    begin
        bank_d = bank_q;
        if (reset_bank_op || wakeup)
            bank_d = 1'b0;
        else if (set_bank_op)
            bank_d = 1'b1;
    end

    always_comb
    begin
        state_d = state_q;
        page_d = page_q;
        low_d = low_q;
        rom_rd_d = 1'b0;
        rom_addr_d = rom_addr_q;
        push_d = 1'b0;
        swdata_d = swdata_q;
        pop_d = 1'b0;
        pc_we_d = 1'b0;
        pc_wdata_d = pc_wdata_q;
        b_we_d = 1'b0;
        b_wdata_d = b_wdata_q;
        a_we_d = 1'b0;
        a_wdata_d = a_wdata_q;
        dp_we_d = 1'b0;
        dp_wdata_d = dp_wdata_q;
        case (state_q)
            ST_IDLE:
            begin
                if (start_tab)
                begin
                    // no overflow check: software keeps a level free
                    push_d = 1'b1;
                    swdata_d = pc_in;
                    // bank bit extends the six-bit field to 0..127
                    page_d = {bank_q,
                        instr_code[TAB_OP_LSB-1:0]};
                    low_d = {data_pointer_high, acc_in};
                    state_d = ST_FETCH;
                end
                else if (start_presc)
                begin
                    // carry and skip are not touched: no port for them
                    b_we_d = 1'b1;
                    b_wdata_d = timer_prescaler_value[7:4];
                    a_we_d = 1'b1;
                    a_wdata_d = timer_prescaler_value[3:0];
                end
            end
            ST_FETCH:
            begin
                if (cycle_en)
                begin
                    rom_rd_d = 1'b1;
                    rom_addr_d = {page_q, low_q};
                    state_d = ST_LOAD;
                end
            end
            ST_LOAD:
            begin
                if (cycle_en)
                begin
                    dp_we_d = 1'b1;
                    dp_wdata_d = rom_data[9:8];
                    b_we_d = 1'b1;
                    b_wdata_d = rom_data[7:4];
                    a_we_d = 1'b1;
                    a_wdata_d = rom_data[3:0];
                    pc_we_d = 1'b1;
                    pc_wdata_d = stack_rdata;
                    pop_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
        busy_d = (state_d != ST_IDLE);
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
            bank_q <= BANK_RST;
            page_q <= PAGE_RST;
            low_q <= LOW_RST;
            rom_rd_q <= 1'b0;
            rom_addr_q <= PC_RST;
            push_q <= 1'b0;
            swdata_q <= PC_RST;
            pop_q <= 1'b0;
            pc_we_q <= 1'b0;
            pc_wdata_q <= PC_RST;
            b_we_q <= 1'b0;
            b_wdata_q <= NIB_RST;
            a_we_q <= 1'b0;
            a_wdata_q <= NIB_RST;
            dp_we_q <= 1'b0;
            dp_wdata_q <= DP_RST;
            busy_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            bank_q <= bank_d;
            page_q <= page_d;
            low_q <= low_d;
            rom_rd_q <= rom_rd_d;
            rom_addr_q <= rom_addr_d;
            push_q <= push_d;
            swdata_q <= swdata_d;
            pop_q <= pop_d;
            pc_we_q <= pc_we_d;
            pc_wdata_q <= pc_wdata_d;
            b_we_q <= b_we_d;
            b_wdata_q <= b_wdata_d;
            a_we_q <= a_we_d;
            a_wdata_q <= a_wdata_d;
            dp_we_q <= dp_we_d;
            dp_wdata_q <= dp_wdata_d;
            busy_q <= busy_d;
        end
    end

    assign rom_rd = rom_rd_q;
    assign rom_addr = rom_addr_q;
    assign stack_push = push_q;
    assign stack_wdata = swdata_q;
    assign stack_pop = pop_q;
    assign pc_we = pc_we_q;
    assign pc_wdata = pc_wdata_q;
    assign b_we = b_we_q;
    assign b_wdata = b_wdata_q;
    assign a_we = a_we_q;
    assign a_wdata = a_wdata_q;
    assign dp_we = dp_we_q;
    assign dp_wdata = dp_wdata_q;
    assign busy = busy_q;
    assign bank_upper = bank_q;

    sequence s_tab_start;
        start_tab;
    endsequence
    sequence s_load_step;
        (state_q == ST_LOAD) && cycle_en;
    endsequence

    property p_tab_push;
        @(posedge mclk) disable iff (!rst_n)
        s_tab_start |=> push_q && (swdata_q == $past(pc_in)) && !pop_q;
    endproperty
    a_tab_push: assert property (p_tab_push)
        else $error("lookup did not push pc");

    property p_tab_page;
        @(posedge mclk) disable iff (!rst_n)
        s_tab_start |=> page_q == {$past(bank_q), $past(instr_code[5:0])};
    endproperty
    a_tab_page: assert property (p_tab_page)
        else $error("page not formed from bank and field");

    property p_fetch_addr;
        @(posedge mclk) disable iff (!rst_n)
        (state_q == ST_FETCH) && cycle_en |=>
            rom_rd_q && (rom_addr_q == {$past(page_q), $past(low_q)})
            && (state_q == ST_LOAD);
    endproperty
    a_fetch_addr: assert property (p_fetch_addr)
        else $error("rom address wrong in fetch step");

    property p_load_split;
        @(posedge mclk) disable iff (!rst_n)
        s_load_step |=> dp_we_q && b_we_q && a_we_q
            && (dp_wdata_q == $past(rom_data[9:8]))
            && (b_wdata_q == $past(rom_data[7:4]))
            && (a_wdata_q == $past(rom_data[3:0]));
    endproperty
    a_load_split: assert property (p_load_split)
        else $error("rom word split wrong");

    property p_restore;
        @(posedge mclk) disable iff (!rst_n)
        s_load_step |=> pc_we_q && pop_q
            && (pc_wdata_q == $past(stack_rdata)) && (state_q == ST_IDLE);
    endproperty
    a_restore: assert property (p_restore)
        else $error("pc not restored or stack not popped");

    property p_three_steps;
        @(posedge mclk) disable iff (!rst_n)
        s_tab_start ##1 ((state_q == ST_FETCH) && cycle_en) ##1 s_load_step
            |=> pc_we_q && !busy_q;
    endproperty
    a_three_steps: assert property (p_three_steps)
        else $error("lookup did not finish on third cycle");

    property p_bank;
        @(posedge mclk) disable iff (!rst_n)
        (reset_bank_op || wakeup) |=> !bank_q;
    endproperty
    a_bank: assert property (p_bank)
        else $error("bank not cleared");

    property p_bank_set;
        @(posedge mclk) disable iff (!rst_n)
        set_bank_op && !reset_bank_op && !wakeup |=> bank_q;
    endproperty
    a_bank_set: assert property (p_bank_set)
        else $error("bank not set");

    property p_presc;
        @(posedge mclk) disable iff (!rst_n)
        start_presc |=> b_we_q && a_we_q && !push_q && !pc_we_q
            && (state_q == ST_IDLE)
            && (b_wdata_q == $past(timer_prescaler_value[7:4]))
            && (a_wdata_q == $past(timer_prescaler_value[3:0]));
    endproperty
    a_presc: assert property (p_presc)
        else $error("prescaler read wrong");
endmodule : table_lookup_prescaler_read
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import tlp_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic cycle_en = 1'b1;
    logic instr_valid = 1'b0;
    logic [INSTR_W-1:0] instr_code = 10'h000;
    logic [PC_W-1:0] pc_in = 14'h0000;
    logic [2:0] data_pointer_high = 3'h0;
    logic [3:0] acc_in = 4'h0;
    logic [PRESC_W-1:0] timer_prescaler_value = 8'h00;
    logic set_bank_op = 1'b0;
    logic reset_bank_op = 1'b0;
    logic wakeup = 1'b0;
    logic [INSTR_W-1:0] rom_data = 10'h000;
    logic [PC_W-1:0] stack_rdata = 14'h0000;
    logic rom_rd, stack_push, stack_pop, pc_we, b_we, a_we, dp_we, busy;
    logic bank_upper;
    logic [PC_W-1:0] rom_addr, stack_wdata, pc_wdata;
    logic [3:0] b_wdata, a_wdata;
    logic [1:0] dp_wdata;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;

    table_lookup_prescaler_read table_lookup_prescaler_read_inst (
        .mclk(mclk), .rst_n(rst_n), .cycle_en(cycle_en),
        .instr_valid(instr_valid), .instr_code(instr_code), .pc_in(pc_in),
        .data_pointer_high(data_pointer_high), .acc_in(acc_in),
        .timer_prescaler_value(timer_prescaler_value),
        .set_bank_op(set_bank_op), .reset_bank_op(reset_bank_op),
        .wakeup(wakeup), .rom_data(rom_data), .rom_rd(rom_rd),
        .rom_addr(rom_addr), .stack_rdata(stack_rdata),
        .stack_push(stack_push), .stack_wdata(stack_wdata),
        .stack_pop(stack_pop), .pc_we(pc_we), .pc_wdata(pc_wdata),
        .b_we(b_we), .b_wdata(b_wdata), .a_we(a_we), .a_wdata(a_wdata),
        .dp_we(dp_we), .dp_wdata(dp_wdata), .busy(busy),
        .bank_upper(bank_upper)
    );

    initial
    begin
        forever #2 mclk = ~mclk;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    // a hung handshake would otherwise stall the run forever
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            num_errors++;
            end_sim();
        end
    end

    task automatic chk(input string what, input logic [13:0] exp,
                       input logic [13:0] got);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic test_presc();
        @(posedge mclk);
        instr_valid <= 1'b1;
        instr_code <= PRESC_OP;
        timer_prescaler_value <= 8'ha5;
        @(posedge mclk);
        timer_prescaler_value <= 8'h3c;
        #1;
        chk("b_we", 14'(b_we), 14'h1);
        chk("b_wdata", 14'(b_wdata), 14'ha);
        chk("a_wdata", 14'(a_wdata), 14'h5);
        chk("busy", 14'(busy), 14'h0);
        chk("stack_push", 14'(stack_push), 14'h0);
        @(posedge mclk);
        instr_code <= 10'h276;
        #1;
        chk("a_we", 14'(a_we), 14'h1);
        chk("b_wdata", 14'(b_wdata), 14'h3);
        chk("a_wdata", 14'(a_wdata), 14'hc);
        @(posedge mclk);
        instr_valid <= 1'b0;
        #1;
        chk("b_we", 14'(b_we), 14'h0);
        $display("test prescaler read done");
    endtask : test_presc

    // a prescaler read is offered while busy and must be ignored
    task automatic test_lookup(input logic [5:0] pg, input logic bk);
        logic [13:0] pc;
        logic [13:0] adr;
        pc = 14'h1230 ^ 14'(pg);
        adr = {bk, pg, 3'h5, 4'h9};
        @(posedge mclk);
        instr_valid <= 1'b1;
        instr_code <= {TAB_OP_HI, pg};
        pc_in <= pc;
        data_pointer_high <= 3'h5;
        acc_in <= 4'h9;
        rom_data <= 10'h2b7;
        stack_rdata <= pc;
        @(posedge mclk);
        instr_code <= PRESC_OP;
        #1;
        chk("stack_push", 14'(stack_push), 14'h1);
        chk("stack_wdata", stack_wdata, pc);
        chk("busy", 14'(busy), 14'h1);
        @(posedge mclk);
        instr_valid <= 1'b0;
        #1;
        chk("rom_rd", 14'(rom_rd), 14'h1);
        chk("rom_addr", rom_addr, adr);
        chk("b_we", 14'(b_we), 14'h0);
        @(posedge mclk);
        #1;
        chk("pc_we", 14'(pc_we), 14'h1);
        chk("pc_wdata", pc_wdata, pc);
        chk("stack_pop", 14'(stack_pop), 14'h1);
        chk("dp_we", 14'(dp_we), 14'h1);
        chk("a_we", 14'(a_we), 14'h1);
        chk("rom_rd", 14'(rom_rd), 14'h0);
        chk("dp_wdata", 14'(dp_wdata), 14'h2);
        chk("b_wdata", 14'(b_wdata), 14'hb);
        chk("a_wdata", 14'(a_wdata), 14'h7);
        chk("busy", 14'(busy), 14'h0);
        $display("test table lookup done");
    endtask : test_lookup

    // divided instruction clock: the lookup waits for each enable
    task automatic test_slow_lookup();
        logic [13:0] adr;
        adr = {1'b0, 6'h2a, 3'h2, 4'h6};
        @(posedge mclk);
        cycle_en <= 1'b0;
        instr_valid <= 1'b1;
        instr_code <= PRESC_OP;
        pc_in <= 14'h0abc;
        data_pointer_high <= 3'h2;
        acc_in <= 4'h6;
        rom_data <= 10'h1e4;
        stack_rdata <= 14'h0abc;
        @(posedge mclk);
        cycle_en <= 1'b1;
        instr_code <= {TAB_OP_HI, 6'h2a};
        #1;
        chk("b_we", 14'(b_we), 14'h0);
        @(posedge mclk);
        cycle_en <= 1'b0;
        instr_valid <= 1'b0;
        #1;
        chk("stack_push", 14'(stack_push), 14'h1);
        chk("stack_wdata", stack_wdata, 14'h0abc);
        @(posedge mclk);
        cycle_en <= 1'b1;
        #1;
        chk("rom_rd", 14'(rom_rd), 14'h0);
        chk("busy", 14'(busy), 14'h1);
        @(posedge mclk);
        cycle_en <= 1'b0;
        #1;
        chk("rom_rd", 14'(rom_rd), 14'h1);
        chk("rom_addr", rom_addr, adr);
        @(posedge mclk);
        cycle_en <= 1'b1;
        #1;
        chk("pc_we", 14'(pc_we), 14'h0);
        chk("busy", 14'(busy), 14'h1);
        @(posedge mclk);
        #1;
        chk("pc_we", 14'(pc_we), 14'h1);
        chk("pc_wdata", pc_wdata, 14'h0abc);
        chk("dp_wdata", 14'(dp_wdata), 14'h1);
        chk("b_wdata", 14'(b_wdata), 14'he);
        chk("a_wdata", 14'(a_wdata), 14'h4);
        chk("busy", 14'(busy), 14'h0);
        $display("test slow table lookup done");
    endtask : test_slow_lookup

    // reset in mid-lookup drops the lookup and returns to the lower bank
    task automatic test_reset();
        @(posedge mclk);
        instr_valid <= 1'b1;
        instr_code <= {TAB_OP_HI, 6'h01};
        @(posedge mclk);
        rst_n <= 1'b0;
        instr_valid <= 1'b0;
        #1;
        chk("stack_push", 14'(stack_push), 14'h1);
        @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        chk("busy", 14'(busy), 14'h0);
        chk("bank_upper", 14'(bank_upper), 14'h0);
        chk("stack_push", 14'(stack_push), 14'h0);
        @(posedge mclk);
        #1;
        chk("rom_rd", 14'(rom_rd), 14'h0);
        chk("pc_we", 14'(pc_we), 14'h0);
        $display("test reset done");
    endtask : test_reset

    task automatic bank(input logic s, input logic r, input logic w,
                        input logic exp);
        @(posedge mclk);
        set_bank_op <= s;
        reset_bank_op <= r;
        wakeup <= w;
        @(posedge mclk);
        set_bank_op <= 1'b0;
        reset_bank_op <= 1'b0;
        wakeup <= 1'b0;
        #1;
        chk("bank_upper", 14'(bank_upper), 14'(exp));
    endtask : bank

    initial
    begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        chk("bank_upper", 14'(bank_upper), 14'h0);
        chk("busy", 14'(busy), 14'h0);
        test_presc();
        test_lookup(6'h15, 1'b0);
        bank(1'b1, 1'b0, 1'b0, 1'b1);
        test_lookup(6'h3f, 1'b1);
        bank(1'b0, 1'b0, 1'b1, 1'b0);
        bank(1'b1, 1'b0, 1'b0, 1'b1);
        bank(1'b1, 1'b1, 1'b0, 1'b0);
        test_lookup(6'h00, 1'b0);
        $display("test bank select done");
        test_slow_lookup();
        bank(1'b1, 1'b0, 1'b0, 1'b1);
        test_reset();
        end_sim();
    end
endmodule : testbench
`default_nettype wire
